// ### common/sasrc_regs.svh
// Constants for the converter serial readout chain: widths, frame lengths, command code and conversion timing.
//
// Notes on behaviour
// - SDI high, strobe rise: convert, select mode, release SDO.
// - SDI and strobe both low: SDO driven low.
// - Plain mode: SDI low shows MSB, falls shift.
// - Output bit stays valid across both SCK edges.
// - Plain mode: release SDO after 16 falls (22 with status) or SDI high.
// - Busy mode: SDO driven low at conversion end.
// - Busy mode: MSB first, release after 17 (23 with status) or SDI.
// - SDI low, strobe rise: daisy mode, no busy.
// - Daisy: MSB at completion, falls shift remaining bits.
// - Daisy: SDI enters shift register on SCK rises.
// - Register writes shift in on SDI, strobe low.
// - No register reads; optional six status bits appended.
// - Turbo never active in daisy mode.
`ifndef SASRC_REGS_SVH
`define SASRC_REGS_SVH

// ----------------------------------------------------------------------------
// Frame shape
// ----------------------------------------------------------------------------
`define SASRC_RES_W        16
`define SASRC_STAT_W       6
`define SASRC_FRAME_W      23
`define SASRC_CNT_W        5
`define SASRC_LEN_PLAIN    5'h10
`define SASRC_LEN_STATUS   5'h16
`define SASRC_LEN_PASS     5'h08
`define SASRC_CNT_SAT      5'h1F

// ----------------------------------------------------------------------------
// Configuration word written over SDI
// ----------------------------------------------------------------------------
`define SASRC_CMD_WRITE    8'h14
`define SASRC_CFG_RESET    8'h00
`define SASRC_CFG_STAT_EN  0
`define SASRC_CFG_HIGHZ    1
`define SASRC_CFG_SPAN     2
`define SASRC_CFG_TURBO    3

// ----------------------------------------------------------------------------
// Conversion timing
// ----------------------------------------------------------------------------
`define SASRC_CLK_PERIOD_NS 40
`define SASRC_T_CONV_MIN_NS 300
`define SASRC_T_CONV_MAX_NS 500

`endif

// ### common/sasrc_pkg.sv
// Types shared by the readout chain core and its link-clock shifter.
`include "sasrc_regs.svh"

package sasrc_pkg;

  // Sequencer states of the system-clock side.
  typedef enum logic [1:0] {SASRC_IDLE, SASRC_CONV, SASRC_READ} sasrc_state_t;

  // Interface mode: plain or daisy chosen at the strobe rising edge, busy at the minimum time.
  typedef enum logic [1:0] {SASRC_CS_PLAIN, SASRC_CS_BUSY, SASRC_DAISY} sasrc_mode_t;

  // Frame handed to the link side; held stable while the link runs.
  typedef struct packed {
    logic [`SASRC_FRAME_W-1:0] word;
    logic [`SASRC_CNT_W-1:0]   len;
    logic                      endless;
  } sasrc_frame_t;

  // State returned by the link side.
  typedef struct packed {
    logic                      bit_val;
    logic                      fresh;
    logic                      done;
    logic [`SASRC_FRAME_W-1:0] hist;
  } sasrc_link_t;

endpackage

// ### rtl/sasrc_link.sv
// Link-clock shifter: serial output, SDI history and edge counters on SCK.
`timescale 1ns/1ps
`include "sasrc_regs.svh"

module sasrc_link (
  // Link clock and serial input
  input  wire logic                  sck_in,
  input  wire logic                  sdi_in,
  // Reset and frame control from the system domain
  input  wire logic                  rstn_in,
  input  wire logic                  clr_in,
  input  wire sasrc_pkg::sasrc_frame_t frame_in,
  // Link state back to the system domain
  output sasrc_pkg::sasrc_link_t     link_out
);

  logic [`SASRC_CNT_W-1:0]   rise_q;
  logic [`SASRC_CNT_W-1:0]   fall_q;
  logic [`SASRC_FRAME_W-1:0] hist_q;
  logic                      bit_q;
  logic                      done_q;
  logic                      clr_n;
  logic                      top_bit;
  logic [`SASRC_CNT_W-1:0]   word_idx;
  logic [`SASRC_CNT_W-1:0]   hist_idx;
  logic [`SASRC_CNT_W-1:0]   fall_next;

  // Saturating increment shared by both edge counters.
  function automatic logic [`SASRC_CNT_W-1:0] sat_inc(input logic [`SASRC_CNT_W-1:0] v);
    sat_inc = (v == `SASRC_CNT_SAT) ? v : v + 1'b1;
  endfunction

  // The clock may stand still between frames, so the frame end is a clear
  // driven from the system side rather than anything counted on SCK.
  assign clr_n = rstn_in & ~clr_in;

  // The conceptual chain register is the loaded frame followed by SDI
  // history; its top bit is the frame bit until len rises have passed.
  assign word_idx  = `SASRC_CNT_W'(`SASRC_FRAME_W - 1) - rise_q;
  assign hist_idx  = frame_in.len - 1'b1;
  assign top_bit   = (rise_q < frame_in.len) ? frame_in.word[word_idx] : hist_q[hist_idx];
  assign fall_next = sat_inc(fall_q);

  // SDI is taken on every rising edge so upstream data passes through.
  always_ff @(posedge sck_in or negedge rstn_in)
  begin
    if (!rstn_in)
      hist_q <= '0;
    else
      hist_q <= {hist_q[`SASRC_FRAME_W-2:0], sdi_in};
  end

  // Rising edges of the current frame.
  always_ff @(posedge sck_in or negedge clr_n)
  begin
    if (!clr_n)
      rise_q <= '0;
    else
      rise_q <= sat_inc(rise_q);
  end

  // New bit on each falling edge; it then holds over the next rising edge.
  always_ff @(negedge sck_in or negedge clr_n)
  begin
    if (!clr_n)
    begin
      fall_q <= '0;
      bit_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      fall_q <= fall_next;
      bit_q  <= top_bit;
      done_q <= !frame_in.endless && (fall_next >= frame_in.len);
    end
  end

  // Results for the pin logic.
  assign link_out.bit_val = bit_q;
  assign link_out.fresh   = (fall_q == '0);
  assign link_out.done    = done_q;
  assign link_out.hist    = hist_q;

endmodule

// ### rtl/sasrc_readout.sv
// Serial readout chain core: strobe sequencing, conversion timing, frames and SDO pin control.
`timescale 1ns/1ps
`include "sasrc_regs.svh"

module sasrc_readout #(
  parameter int T_CONV_MIN_NS = `SASRC_T_CONV_MIN_NS,
  parameter int T_CONV_MAX_NS = `SASRC_T_CONV_MAX_NS
) (
  // System clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  // Serial link pins
  input  wire logic                     sck_in,
  input  wire logic                     convert_strobe_in,
  input  wire logic                     sdi_in,
  output logic                          sdo_out,
  output logic                          sdo_oe_n_out,
  // Converter core side
  input  wire logic [`SASRC_RES_W-1:0]  result_in,
  input  wire logic                     clamp_flag_in,
  output logic                          converting_out,
  output logic [7:0]                    cfg_out
);

  // --------------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------------
  localparam int P_NS         = `SASRC_CLK_PERIOD_NS;
  localparam int MIN_RAW      = (T_CONV_MIN_NS + P_NS - 1) / P_NS;
  localparam int MAX_RAW      = T_CONV_MAX_NS / P_NS;
  localparam int CONV_MIN_CYC = (MIN_RAW < 1) ? 1 : MIN_RAW;
  localparam int CONV_MAX_CYC = (MAX_RAW < CONV_MIN_CYC) ? CONV_MIN_CYC : MAX_RAW;
  localparam int CW           = $clog2(CONV_MAX_CYC + 1);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [1:0]                cnv_sync_q;
  logic [1:0]                sdi_sync_q;
  logic                      cnv_prev_q;
  logic                      sdi_prev_q;
  logic                      cnv_s;
  logic                      sdi_s;
  logic                      cnv_rise;
  logic                      cnv_fall;
  logic                      sdi_rise;
  sasrc_pkg::sasrc_state_t   state_q;
  sasrc_pkg::sasrc_state_t   state_d;
  sasrc_pkg::sasrc_mode_t    mode_q;
  sasrc_pkg::sasrc_mode_t    mode_d;
  logic [CW-1:0]             conv_cnt_q;
  logic [CW-1:0]             conv_cnt_d;
  logic                      at_min;
  logic                      at_max;
  logic                      ended_q;
  logic                      ended_d;
  logic                      drive_q;
  logic                      drive_d;
  logic                      clr_q;
  logic                      run_d;
  logic [7:0]                cfg_q;
  logic [7:0]                cfg_d;
  logic                      wr_hit;
  logic [7:0]                wr_data;
  logic [`SASRC_STAT_W-1:0]  status;
  logic                      stat_en;
  sasrc_pkg::sasrc_frame_t   frame_q;
  sasrc_pkg::sasrc_frame_t   frame_d;
  sasrc_pkg::sasrc_frame_t   frame_read;
  sasrc_pkg::sasrc_frame_t   frame_pass;
  sasrc_pkg::sasrc_link_t    link;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Strobe and SDI levels cross on two flops; edge detectors read stage two only.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnv_sync_q <= 2'h0;
      sdi_sync_q <= 2'h3;
      cnv_prev_q <= 1'b0;
      sdi_prev_q <= 1'b1;
    end
    else
    begin
      cnv_sync_q <= {cnv_sync_q[0], convert_strobe_in};
      sdi_sync_q <= {sdi_sync_q[0], sdi_in};
      cnv_prev_q <= cnv_sync_q[1];
      sdi_prev_q <= sdi_sync_q[1];
    end
  end

  // Edge decode of the synchronised levels.
  assign cnv_s    = cnv_sync_q[1];
  assign sdi_s    = sdi_sync_q[1];
  assign cnv_rise = cnv_s & ~cnv_prev_q;
  assign cnv_fall = ~cnv_s & cnv_prev_q;
  assign sdi_rise = sdi_s & ~sdi_prev_q;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Conversion runs to the maximum time whatever the strobe does meanwhile;
  // the minimum time is where SDI picks the busy indicator.
  assign at_min = (conv_cnt_q == CW'(CONV_MIN_CYC - 1));
  assign at_max = (conv_cnt_q == CW'(CONV_MAX_CYC - 1));

  always_comb
  begin
    state_d    = state_q;
    mode_d     = mode_q;
    conv_cnt_d = conv_cnt_q;
    ended_d    = ended_q;
    case (state_q)
      sasrc_pkg::SASRC_IDLE:
      begin
        if (cnv_rise)
        begin
          state_d    = sasrc_pkg::SASRC_CONV;
          mode_d     = sdi_s ? sasrc_pkg::SASRC_CS_PLAIN : sasrc_pkg::SASRC_DAISY;
          conv_cnt_d = '0;
          ended_d    = 1'b0;
        end
      end
      sasrc_pkg::SASRC_CONV:
      begin
        conv_cnt_d = conv_cnt_q + 1'b1;
        if (at_min && !sdi_s && mode_q == sasrc_pkg::SASRC_CS_PLAIN)
          mode_d = sasrc_pkg::SASRC_CS_BUSY;
        if (at_max)
          state_d = sasrc_pkg::SASRC_READ;
      end
      sasrc_pkg::SASRC_READ:
      begin
        if (sdi_rise && mode_q != sasrc_pkg::SASRC_DAISY)
          ended_d = 1'b1;
        if (cnv_fall)
          state_d = sasrc_pkg::SASRC_IDLE;
      end
      default:
        state_d = sasrc_pkg::SASRC_IDLE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Frame building
  // --------------------------------------------------------------------------
  // Status word: clamp flag, span, high-z, turbo (never on here), two reserved zeros.
  assign stat_en = cfg_q[`SASRC_CFG_STAT_EN];
  assign status  = {clamp_flag_in, cfg_q[`SASRC_CFG_SPAN], cfg_q[`SASRC_CFG_HIGHZ],
                    1'b0, 2'h0};

  // Busy mode leads with the driven-low bit, so its frame is one longer.
  assign frame_read.word    = (mode_d == sasrc_pkg::SASRC_CS_BUSY) ?
                              {1'b0, result_in, stat_en ? status : 6'h00} :
                              {result_in, stat_en ? status : 6'h00, 1'b0};
  assign frame_read.len     = (stat_en ? `SASRC_LEN_STATUS : `SASRC_LEN_PLAIN) +
                              ((mode_d == sasrc_pkg::SASRC_CS_BUSY) ? 5'h01 : 5'h00);
  assign frame_read.endless = (mode_d == sasrc_pkg::SASRC_DAISY);

  // While the strobe is low SDI data passes on after one byte of delay.
  assign frame_pass.word    = '0;
  assign frame_pass.len     = `SASRC_LEN_PASS;
  assign frame_pass.endless = 1'b1;

  assign frame_d = (state_q == sasrc_pkg::SASRC_CONV && at_max) ? frame_read :
                   (state_q == sasrc_pkg::SASRC_READ && cnv_fall) ? frame_pass : frame_q;

  // --------------------------------------------------------------------------
  // Register write
  // --------------------------------------------------------------------------
  // SCK is idle when the strobe rises, so the history word is quiet and safe
  // to take here even though it lives in the link domain.
  assign wr_hit  = (state_q == sasrc_pkg::SASRC_IDLE) && cnv_rise &&
                   (link.hist[15:8] == `SASRC_CMD_WRITE);
  assign wr_data = link.hist[7:0];
  assign cfg_d   = wr_hit ? wr_data : cfg_q;

  // --------------------------------------------------------------------------
  // Pin drive decode
  // --------------------------------------------------------------------------
  // A stale done flag is cleared by the link clear raised at each state change.
  always_comb
  begin
    drive_d = 1'b0;
    case (state_d)
      sasrc_pkg::SASRC_IDLE:
        drive_d = !cnv_s && (!sdi_s || mode_q == sasrc_pkg::SASRC_DAISY);
      sasrc_pkg::SASRC_CONV:
        drive_d = 1'b0;
      sasrc_pkg::SASRC_READ:
        case (mode_d)
          sasrc_pkg::SASRC_CS_PLAIN: drive_d = !sdi_s && !ended_d;
          sasrc_pkg::SASRC_CS_BUSY:  drive_d = !ended_d;
          default:                   drive_d = 1'b1;
        endcase
      default:
        drive_d = 1'b0;
    endcase
  end

  assign run_d = (state_q == state_d) && (state_d == sasrc_pkg::SASRC_IDLE ||
                 (state_d == sasrc_pkg::SASRC_READ && drive_d));

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q    <= sasrc_pkg::SASRC_IDLE;
      mode_q     <= sasrc_pkg::SASRC_CS_PLAIN;
      conv_cnt_q <= '0;
      ended_q    <= 1'b0;
      drive_q    <= 1'b0;
      clr_q      <= 1'b1;
      cfg_q      <= `SASRC_CFG_RESET;
      frame_q    <= '{word: '0, len: `SASRC_LEN_PASS, endless: 1'b1};
    end
    else
    begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      conv_cnt_q <= conv_cnt_d;
      ended_q    <= ended_d;
      drive_q    <= drive_d;
      clr_q      <= !run_d;
      cfg_q      <= cfg_d;
      frame_q    <= frame_d;
    end
  end

  // --------------------------------------------------------------------------
  // Link shifter
  // --------------------------------------------------------------------------
  sasrc_link u_link (
    .sck_in   (sck_in),
    .sdi_in   (sdi_in),
    .rstn_in  (rstn_in),
    .clr_in   (clr_q),
    .frame_in (frame_q),
    .link_out (link)
  );

  // Before the first falling edge the frame MSB stands on the pin.
  assign sdo_out        = link.fresh ? frame_q.word[`SASRC_FRAME_W-1] : link.bit_val;
  assign sdo_oe_n_out   = ~(drive_q & ~link.done);
  assign converting_out = (state_q == sasrc_pkg::SASRC_CONV);
  assign cfg_out        = cfg_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  conv_start_a: assert property ((state_q == sasrc_pkg::SASRC_IDLE && cnv_rise && sdi_s) |=>
      (state_q == sasrc_pkg::SASRC_CONV && mode_q == sasrc_pkg::SASRC_CS_PLAIN && sdo_oe_n_out))
    else $error("Conversion start did not release SDO in chip-select mode");

  idle_low_a: assert property (
      (state_q == sasrc_pkg::SASRC_IDLE && $past(state_q) == sasrc_pkg::SASRC_IDLE &&
      !cnv_s && !sdi_s && !cnv_prev_q) |=> ((!sdo_oe_n_out && !sdo_out) || !link.fresh))
    else $error("SDO not driven low with strobe and SDI low");

  conv_len_a: assert property (($past(state_q) == sasrc_pkg::SASRC_CONV &&
      state_q == sasrc_pkg::SASRC_READ) |-> $past(conv_cnt_q) == CW'(CONV_MAX_CYC - 1))
    else $error("Conversion ended at the wrong count");

  busy_low_a: assert property (
      (state_q == sasrc_pkg::SASRC_READ && $past(state_q) == sasrc_pkg::SASRC_CONV &&
      mode_q == sasrc_pkg::SASRC_CS_BUSY) |=> (!sdo_oe_n_out && !sdo_out))
    else $error("Busy indicator not driven low at completion");

  plain_hiz_a: assert property (
      (state_q == sasrc_pkg::SASRC_READ && mode_q == sasrc_pkg::SASRC_CS_PLAIN &&
      sdi_s) |=> sdo_oe_n_out)
    else $error("SDO driven while SDI high in plain chip-select read");

  daisy_sel_a: assert property ((state_q == sasrc_pkg::SASRC_IDLE && cnv_rise && !sdi_s) |=>
      (mode_q == sasrc_pkg::SASRC_DAISY) ##CONV_MAX_CYC (mode_q == sasrc_pkg::SASRC_DAISY))
    else $error("Daisy mode not kept through conversion");

  daisy_drive_a: assert property (
      (state_q == sasrc_pkg::SASRC_READ && mode_q == sasrc_pkg::SASRC_DAISY &&
      $past(state_q) == sasrc_pkg::SASRC_READ && !cnv_fall) |=> !sdo_oe_n_out)
    else $error("SDO not driven during daisy readback");

  frame_msb_a: assert property (
      (state_q == sasrc_pkg::SASRC_READ && $past(state_q) == sasrc_pkg::SASRC_CONV &&
      mode_q != sasrc_pkg::SASRC_CS_BUSY) |-> frame_q.word[`SASRC_FRAME_W-1 -: `SASRC_RES_W] == $past(result_in))
    else $error("Frame does not start with the result MSB");

  cfg_write_a: assert property (wr_hit |=> cfg_q == $past(wr_data))
    else $error("Write command did not update configuration");

  busy_len_a: assert property (
      (state_q == sasrc_pkg::SASRC_READ && mode_q == sasrc_pkg::SASRC_CS_BUSY) |->
      (frame_q.len == (stat_en ? `SASRC_LEN_STATUS : `SASRC_LEN_PLAIN) + 5'h01) && !frame_q.endless)
    else $error("Busy frame length is not result plus one");

  plain_rd_c: cover property ((state_q == sasrc_pkg::SASRC_READ && mode_q == sasrc_pkg::SASRC_CS_PLAIN &&
      !sdo_oe_n_out));
  busy_rd_c: cover property ((state_q == sasrc_pkg::SASRC_READ && mode_q == sasrc_pkg::SASRC_CS_BUSY &&
      !sdo_oe_n_out));
  daisy_rd_c: cover property ((state_q == sasrc_pkg::SASRC_READ && mode_q == sasrc_pkg::SASRC_DAISY) ##1 cnv_fall);
  cfg_write_c: cover property (wr_hit);

endmodule

// ### sim/sasrc_host.sv
// Host model: drives strobe, SDI and a framed SCK, samples SDO.
`timescale 1ns/1ps

module sasrc_host (
  // System clock and returned data
  input  wire logic clk_in,
  input  wire logic sdo_in,
  // Host-driven pins
  output logic      sck_out,
  output logic      cnv_out,
  output logic      sdi_out
);
  // SCK idles low and only runs inside a frame, never during a conversion.
  initial
  begin
    sck_out = 1'b0;
    cnv_out = 1'b0;
    sdi_out = 1'b1;
  end

  // Strobe and select change after a falling system edge.
  task automatic pins(input logic c, input logic s);
    @(negedge clk_in);
    cnv_out = c;
    sdi_out = s;
  endtask

  // Sends n bits of din on SDI and samples SDO mid high phase.
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_out = din[i];
      #16 sck_out = 1'b1;
      #8 q = {q[30:0], sdo_in};
      #8 sck_out = 1'b0;
    end
  endtask
endmodule

// ### sim/sar_adc_serial_readout_chain_bench.sv
// Self-checking bench for the converter serial readout core.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("BAD at %0t: got %h want %h", $time, a, b); \
    end \
  end

module sar_adc_serial_readout_chain_bench;
  logic        clk_in  = 1'b0;
  logic        rstn_in = 1'b0;
  logic [15:0] res     = 16'h0000;
  logic        clamp   = 1'b0;
  logic [15:0] lfsr    = 16'h0026;
  logic [31:0] q;
  logic [7:0]  cfg;
  logic        sck, convert_strobe, sdi, sdo, oe_n, conv, sdo_pin;
  int          miscompares = 0;
  int          n_tests     = 0;

  // System clock at 25 MHz.
  always #20 clk_in = ~clk_in;

  // The SDO line has a pull-up, so a released pin reads high.
  assign sdo_pin = oe_n ? 1'b1 : sdo;

  // Short conversion times: minimum 8, maximum 16 cycles.
  sasrc_readout #(.T_CONV_MIN_NS(320), .T_CONV_MAX_NS(640)) DUT (
    .clk_in(clk_in), .rstn_in(rstn_in), .sck_in(sck), .convert_strobe_in(convert_strobe),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(oe_n), .result_in(res),
    .clamp_flag_in(clamp), .converting_out(conv), .cfg_out(cfg));

  sasrc_host host (.clk_in(clk_in), .sdo_in(sdo_pin), .sck_out(sck), .cnv_out(convert_strobe), .sdi_out(sdi));

  // One step of the stimulus shift register.
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Status bits that follow the result when enabled.
  function automatic logic [5:0] stat(input logic c, input logic [7:0] g);
    return {c, g[2], g[1], 3'b000};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Waits, bounded, for the converting flag to reach a level.
  task automatic wait_conv(input logic lvl);
    int k;
    k = 0;
    while (conv !== lvl && k < 40)
    begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 40)
    begin
      miscompares++;
      $display("BAD at %0t: converting flag stuck", $time);
    end
  endtask

  // Starts a conversion on fresh random inputs; busy lowers SDI early.
  task automatic convert(input logic s, input logic busy);
    lfsr = step(lfsr);
    @(negedge clk_in);
    res = lfsr;
    clamp = lfsr[0];
    host.pins(1'b1, s);
    wait_conv(1'b1);
    if (busy)
      host.pins(1'b1, 1'b0);
    `CHK(oe_n, 1'b1)
    wait_conv(1'b0);
    waitc(6);
  endtask

  // Main sequence.
  initial
  begin
    waitc(8);
    `CHK({oe_n, conv, cfg}, 10'h200)
    rstn_in = 1'b1;
    // Full read, then a read cut short by SDI rising.
    for (int t = 0; t < 2; t++)
    begin
      convert(1'b1, 1'b0);
      host.pins(1'b1, 1'b0);
      waitc(6);
      host.shift(t ? 8 : 16, 32'h0, q);
      if (t == 0)
        `CHK(q[15:0], res)
      else
        `CHK(q[7:0], res[15:8])
      if (t == 1)
        host.pins(1'b1, 1'b1);
      waitc(6);
      `CHK(oe_n, 1'b1)
      host.pins(1'b0, 1'b0);
      waitc(6);
      `CHK(sdo_pin, 1'b0)
      $display("plain read %0d done", t);
    end
    convert(1'b1, 1'b1);
    `CHK({oe_n, sdo}, 2'b00)
    host.shift(17, 32'h0, q);
    `CHK(q[15:0], res)
    waitc(6);
    `CHK(oe_n, 1'b1)
    host.pins(1'b0, 1'b0);
    $display("busy read done");
    convert(1'b0, 1'b0);
    `CHK(sdo_pin, res[15])
    lfsr = step(lfsr);
    host.shift(32, {lfsr, 16'h0000}, q);
    `CHK(q, {res, lfsr})
    host.pins(1'b0, 1'b0);
    waitc(6);
    $display("chain read done");
    // Write enables status, high-z and span; the command leaves SDO one byte late.
    host.shift(16, {16'h0000, 8'h14, 8'h07}, q);
    `CHK(q[15:0], 16'h0014)
    host.pins(1'b0, 1'b1);
    waitc(6);
    convert(1'b1, 1'b0);
    `CHK(cfg, 8'h07)
    host.pins(1'b1, 1'b0);
    waitc(6);
    host.shift(22, 32'h0, q);
    `CHK(q[21:0], {res, stat(clamp, 8'h07)})
    waitc(6);
    `CHK(oe_n, 1'b1)
    $display("write and status read done");
    report_and_stop();
  end

  // Watchdog well beyond the expected run length.
  initial
  begin
    #300us;
    miscompares++;
    $display("BAD at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
